//--- logic/cfgm_pkg.sv
// shared constants and types for the configuration message agent
package cfgm_pkg;

    // ------------------------------------------------------------
    // control token values on the channel
    // ------------------------------------------------------------
    localparam logic [7:0] TOK_END = 8'h01;
    localparam logic [7:0] TOK_ACK = 8'h03;
    localparam logic [7:0] TOK_NACK = 8'h04;
    localparam logic [7:0] TOK_WRITE = 8'hC0;
    localparam logic [7:0] TOK_READ = 8'hC1;
    localparam logic [7:0] TOK_PWRITE = 8'h24;
    localparam logic [7:0] TOK_PREAD = 8'h25;

    // ------------------------------------------------------------
    // resource codes in the low part of a destination
    // ------------------------------------------------------------
    localparam logic [15:0] RES_TILE = 16'hC20C;
    localparam logic [15:0] RES_NODE = 16'hC30C;
    localparam logic [7:0] RES_PERIPH = 8'h02;

    // ------------------------------------------------------------
    // message field lengths in bytes and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RET_BYTES = 8'h03;
    localparam logic [7:0] REG_BYTES = 8'h02;
    localparam logic [7:0] PREG_BYTES = 8'h01;
    localparam logic [7:0] WORD_BYTES = 8'h04;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

    // target register space selected by the destination
    typedef enum logic [1:0] {
        SP_TILE = 2'h0,
        SP_NODE = 2'h1,
        SP_PERIPH = 2'h2
    } cfgm_space_t;

endpackage

//--- logic/cfgm_reply_if.sv
// request from the parser to the reply token sender
`timescale 1ns/1ns
`default_nettype none
interface cfgm_reply_if;
    logic go;
    logic ok;
    logic [2:0] nbytes;
    logic [31:0] data;
    logic [23:0] ret;
    logic done;

    modport agent (output go, ok, nbytes, data, ret, input done);
    modport sender (input go, ok, nbytes, data, ret, output done);
endinterface
`default_nettype wire

//--- logic/cfgm_reply.sv
// reply token sender: status token, optional data bytes, end token
`timescale 1ns/1ns
`default_nettype none
module cfgm_reply
    import cfgm_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // request from the parser
    cfgm_reply_if.sender rp,
    // outgoing token stream
    output logic tx_valid,
    output logic tx_ctrl,
    output logic [7:0] tx_data,
    output logic [23:0] tx_dest,
    input wire logic tx_ready
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        RS_IDLE = 2'b00,
        RS_HEAD = 2'b01,
        RS_BODY = 2'b11,
        RS_TAIL = 2'b10
    } cfgm_rstate_t;

    typedef struct packed {
        cfgm_rstate_t st;
        logic [2:0] cnt;
        logic [2:0] n;
        logic [31:0] shift;
        logic valid;
        logic ctrl;
        logic [7:0] data;
        logic [23:0] dest;
        logic done;
    } cfgm_rreg_t;

    cfgm_rreg_t s;
    cfgm_rreg_t next_s;
    logic sent;

    assign sent = s.valid && tx_ready;

    // ------------------------------------------------------------
    // sequencing
    // ------------------------------------------------------------
    // data goes out most significant byte first, so the word is aligned to the top
    always_comb begin
        next_s = s;
        next_s.done = 1'b0;
        unique case (s.st)
            RS_IDLE: begin
                if (rp.go) begin
                    next_s.st = RS_HEAD;
                    next_s.valid = 1'b1;
                    next_s.ctrl = 1'b1;
                    next_s.data = rp.ok ? TOK_ACK : TOK_NACK;
                    next_s.dest = rp.ret;
                    next_s.n = rp.ok ? rp.nbytes : 3'd0;
                    next_s.cnt = 3'd0;
                    next_s.shift = rp.data << {3'd4 - rp.nbytes, 3'b000};
                end
            end
            RS_HEAD: begin
                if (sent) begin
                    if (s.n != 3'd0) begin
                        next_s.st = RS_BODY;
                        next_s.ctrl = 1'b0;
                        next_s.data = s.shift[31:24];
                        next_s.shift = {s.shift[23:0], 8'h00};
                    end else begin
                        next_s.st = RS_TAIL;
                        next_s.data = TOK_END;
                    end
                end
            end
            RS_BODY: begin
                if (sent) begin
                    next_s.cnt = s.cnt + 3'd1;
                    if (s.cnt + 3'd1 == s.n) begin
                        next_s.st = RS_TAIL;
                        next_s.ctrl = 1'b1;
                        next_s.data = TOK_END;
                    end else begin
                        next_s.data = s.shift[31:24];
                        next_s.shift = {s.shift[23:0], 8'h00};
                    end
                end
            end
            RS_TAIL: begin
                if (sent) begin
                    next_s.st = RS_IDLE;
                    next_s.valid = 1'b0;
                    next_s.done = 1'b1;
                end
            end
        endcase
    end

    // state register
    always_ff @(posedge clk) begin
        if (!resetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign tx_valid = s.valid;
    assign tx_ctrl = s.ctrl;
    assign tx_data = s.data;
    assign tx_dest = s.dest;
    assign rp.done = s.done;

endmodule
`default_nettype wire

//--- logic/cfgm_agent.sv
// configuration register message agent: parses requests, runs the access, replies
`timescale 1ns/1ns
`default_nettype none
module cfgm_agent
    import cfgm_pkg::*;
#(
    parameter int MAX_PBYTES = 4
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // identity of this tile and node
    input wire logic [15:0] tile_id,
    input wire logic [15:0] node_id,
    // incoming token stream
    input wire logic rx_valid,
    input wire logic rx_ctrl,
    input wire logic [7:0] rx_data,
    input wire logic [31:0] rx_dest,
    output logic rx_ready,
    // register target port
    output logic reg_req,
    output logic reg_we,
    output logic [1:0] reg_space,
    output logic [7:0] reg_periph,
    output logic [15:0] reg_addr,
    output logic [7:0] reg_size,
    output logic [31:0] reg_wdata,
    input wire logic reg_ack,
    input wire logic reg_err,
    input wire logic [31:0] reg_rdata,
    // outgoing token stream
    output logic tx_valid,
    output logic tx_ctrl,
    output logic [7:0] tx_data,
    output logic [23:0] tx_dest,
    input wire logic tx_ready
);

    // ------------------------------------------------------------
    // elaboration check
    // ------------------------------------------------------------
    // peripheral data is held in one word, so more than four bytes cannot be served
    if (MAX_PBYTES < 1 || MAX_PBYTES > 4) begin : g_bad_param
        $error("MAX_PBYTES must lie between 1 and 4");
    end

    localparam logic [7:0] PMAX = 8'(MAX_PBYTES);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RET = 3'b001,
        ST_REG = 3'b011,
        ST_SIZE = 3'b010,
        ST_DATA = 3'b110,
        ST_TAIL = 3'b111,
        ST_ACCESS = 3'b101,
        ST_REPLY = 3'b100
    } cfgm_state_t;

    typedef struct packed {
        cfgm_state_t st;
        logic [7:0] cnt;
        logic silent;
        logic bad;
        logic we;
        logic [1:0] space;
        logic [7:0] periph;
        logic [23:0] ret;
        logic [15:0] addr;
        logic [7:0] size;
        logic [31:0] wdata;
        logic [31:0] rdata;
        logic ok;
        logic rx_ready;
        logic reg_req;
        logic rp_go;
    } cfgm_areg_t;

    cfgm_areg_t s;
    cfgm_areg_t next_s;
    cfgm_reply_if rp ();

    logic tok;
    logic is_end;
    logic hit_tile;
    logic hit_node;
    logic hit_periph;
    logic [7:0] data_total;
    logic [7:0] reg_total;

    // ------------------------------------------------------------
    // decode of the incoming token
    // ------------------------------------------------------------
    assign tok = rx_valid && s.rx_ready;
    assign is_end = rx_ctrl && rx_data == TOK_END;
    assign hit_tile = rx_dest == {tile_id, RES_TILE};
    assign hit_node = rx_dest == {node_id, RES_NODE};
    assign hit_periph = rx_dest[31:16] == node_id && rx_dest[7:0] == RES_PERIPH;
    assign reg_total = (s.space == SP_PERIPH) ? PREG_BYTES : REG_BYTES;
    assign data_total = (s.space == SP_PERIPH) ? s.size : WORD_BYTES;

    // ------------------------------------------------------------
    // message parser and access sequencer
    // ------------------------------------------------------------
    always_comb begin
        next_s = s;
        next_s.reg_req = 1'b0;
        next_s.rp_go = 1'b0;
        unique case (s.st)
            ST_IDLE: begin
                if (tok && !is_end) begin
                    next_s.cnt = 8'h00;
                    next_s.bad = 1'b0;
                    next_s.silent = 1'b0;
                    next_s.addr = 16'h0000;
                    next_s.wdata = ZERO_WORD;
                    next_s.size = 8'h00;
                    next_s.periph = rx_dest[15:8];
                    next_s.st = ST_RET;
                    next_s.space = hit_periph ? SP_PERIPH : (hit_tile ? SP_TILE : SP_NODE);
                    next_s.we = rx_data == TOK_WRITE || rx_data == TOK_PWRITE;
                    if (hit_periph) begin
                        next_s.bad = !(rx_data == TOK_PWRITE || rx_data == TOK_PREAD);
                    end else begin
                        next_s.bad = !(rx_data == TOK_WRITE || rx_data == TOK_READ);
                    end
                    // foreign destination or stray data: swallow without reply
                    if (!rx_ctrl || !(hit_tile || hit_node || hit_periph)) begin
                        next_s.silent = 1'b1;
                        next_s.st = ST_TAIL;
                    end
                end
            end
            ST_RET: begin
                if (tok) begin
                    if (is_end) begin
                        // no return address yet, so there is nobody to answer
                        next_s.st = ST_IDLE;
                    end else if (rx_ctrl) begin
                        next_s.silent = 1'b1;
                        next_s.st = ST_TAIL;
                    end else begin
                        // return channel-end, most significant byte first
                        next_s.ret = {s.ret[15:0], rx_data};
                        next_s.cnt = s.cnt + 8'h01;
                        if (s.cnt + 8'h01 == RET_BYTES) begin
                            next_s.cnt = 8'h00;
                            next_s.st = ST_REG;
                        end
                    end
                end
            end
            ST_REG, ST_SIZE, ST_DATA: begin
                if (tok && rx_ctrl) begin
                    // truncated message fails with no access
                    next_s.bad = 1'b1;
                    next_s.st = ST_TAIL;
                    if (is_end) begin
                        next_s.ok = 1'b0;
                        next_s.rp_go = 1'b1;
                        next_s.st = ST_REPLY;
                    end
                end else if (tok) begin
                    next_s.cnt = s.cnt + 8'h01;
                    if (s.st == ST_REG) begin
                        next_s.addr = {s.addr[7:0], rx_data};
                        if (s.cnt + 8'h01 == reg_total) begin
                            next_s.cnt = 8'h00;
                            if (s.space == SP_PERIPH) begin
                                next_s.st = ST_SIZE;
                            end else begin
                                next_s.st = s.we ? ST_DATA : ST_TAIL;
                            end
                        end
                    end else if (s.st == ST_SIZE) begin
                        // size byte; zero or more than MAX_PBYTES bytes cannot be served
                        next_s.size = rx_data;
                        next_s.cnt = 8'h00;
                        next_s.bad = s.bad || rx_data == 8'h00 || rx_data > PMAX;
                        next_s.st = (s.we && rx_data != 8'h00) ? ST_DATA : ST_TAIL;
                    end else begin
                        // data word collected high byte first
                        next_s.wdata = {s.wdata[23:0], rx_data};
                        if (s.cnt + 8'h01 == data_total) begin
                            next_s.st = ST_TAIL;
                        end
                    end
                end
            end
            ST_TAIL: begin
                if (tok && is_end) begin
                    if (s.silent) begin
                        next_s.st = ST_IDLE;
                    end else if (s.bad) begin
                        next_s.ok = 1'b0;
                        next_s.rp_go = 1'b1;
                        next_s.st = ST_REPLY;
                    end else begin
                        next_s.reg_req = 1'b1;
                        next_s.st = ST_ACCESS;
                    end
                end else if (tok) begin
                    // overlong message
                    next_s.bad = 1'b1;
                end
            end
            ST_ACCESS: begin
                // reply waits for the target to finish
                if (reg_ack) begin
                    next_s.ok = !reg_err;
                    next_s.rdata = reg_rdata;
                    next_s.rp_go = 1'b1;
                    next_s.st = ST_REPLY;
                end
            end
            ST_REPLY: begin
                if (rp.done) begin
                    next_s.st = ST_IDLE;
                end
            end
        endcase
        // input stalls while an access or a reply is in flight
        next_s.rx_ready = next_s.st != ST_ACCESS && next_s.st != ST_REPLY;
    end

    // state register
    always_ff @(posedge clk) begin
        if (!resetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------
    // reply request
    // ------------------------------------------------------------
    // writes carry no data; reads carry a word; peripheral reads carry size bytes
    assign rp.go = s.rp_go;
    assign rp.ok = s.ok;
    assign rp.ret = s.ret;
    assign rp.data = s.rdata;
    assign rp.nbytes = s.we ? 3'd0 : ((s.space == SP_PERIPH) ? s.size[2:0] : 3'd4);

    cfgm_reply u_reply (
        .clk(clk),
        .resetn(resetn),
        .rp(rp.sender),
        .tx_valid(tx_valid),
        .tx_ctrl(tx_ctrl),
        .tx_data(tx_data),
        .tx_dest(tx_dest),
        .tx_ready(tx_ready)
    );

    // ------------------------------------------------------------
    // outputs straight from the state register
    // ------------------------------------------------------------
    assign rx_ready = s.rx_ready;
    assign reg_req = s.reg_req;
    assign reg_we = s.we;
    assign reg_space = s.space;
    assign reg_periph = s.periph;
    assign reg_addr = s.addr;
    assign reg_size = s.size;
    assign reg_wdata = s.wdata;

endmodule
`default_nettype wire

//--- dv/cfgm_agent_checker.sv
// port-level checks for the configuration message agent
`timescale 1ns/1ns
`default_nettype none
module cfgm_agent_checker
    import cfgm_pkg::*;
#(
    parameter int MAX_PBYTES = 4
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // token input
    input wire logic rx_valid,
    input wire logic rx_ctrl,
    input wire logic [7:0] rx_data,
    input wire logic rx_ready,
    // register port
    input wire logic reg_req,
    input wire logic [1:0] reg_space,
    input wire logic [7:0] reg_size,
    input wire logic reg_ack,
    input wire logic reg_err,
    // reply output
    input wire logic tx_valid,
    input wire logic tx_ctrl,
    input wire logic [7:0] tx_data,
    input wire logic [23:0] tx_dest,
    input wire logic tx_ready
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    logic pend;
    // ------------------------------------------------------------
    // helper state and sequences
    // ------------------------------------------------------------
    // access in flight, so a reply may not overtake its register
    always_ff @(posedge clk) begin
        if (!resetn) begin
            pend <= 1'b0;
        end else if (reg_req) begin
            pend <= 1'b1;
        end else if (reg_ack) begin
            pend <= 1'b0;
        end
    end
    sequence s_nack_taken;
        tx_valid && tx_ready && tx_ctrl && tx_data == TOK_NACK;
    endsequence
    sequence s_end_shown;
        ##[0:1] (tx_valid && tx_ctrl && tx_data == TOK_END);
    endsequence
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    req_after_end_a: assert property (
        reg_req |-> $past(rx_valid && rx_ready && rx_ctrl && rx_data == TOK_END))
        else $error("access without a closed message");
    req_one_cycle_a: assert property (reg_req |=> !reg_req)
        else $error("access strobe longer than one cycle");
    input_closed_a: assert property (reg_req |-> !rx_ready && !tx_valid)
        else $error("input open or reply out during access");
    reply_waits_a: assert property ($rose(tx_valid) |-> !pend)
        else $error("reply started before access finished");
    status_first_a: assert property (
        $rose(tx_valid) |-> tx_ctrl && (tx_data == TOK_ACK || tx_data == TOK_NACK))
        else $error("reply does not open with a status token");
    // the answer is registered once in the parser and once in the sender
    err_nack_a: assert property (
        pend && reg_ack && reg_err |=> ##1 tx_valid && tx_ctrl && tx_data == TOK_NACK)
        else $error("failed access not answered with failure");
    ok_ack_a: assert property (
        pend && reg_ack && !reg_err |=> ##1 tx_valid && tx_ctrl && tx_data == TOK_ACK)
        else $error("good access not answered with success");
    tx_hold_a: assert property (
        tx_valid && !tx_ready |=> tx_valid && $stable({tx_ctrl, tx_data, tx_dest}))
        else $error("reply token changed before taken");
    nack_end_a: assert property (s_nack_taken |=> s_end_shown)
        else $error("failure token not followed by end token");
    size_range_a: assert property (
        reg_req && reg_space == SP_PERIPH |-> reg_size != 8'h00 && reg_size <= MAX_PBYTES)
        else $error("peripheral access with bad size");
endmodule
bind cfgm_agent cfgm_agent_checker #(.MAX_PBYTES(MAX_PBYTES)) u_chk (
    .clk(clk), .resetn(resetn), .rx_valid(rx_valid), .rx_ctrl(rx_ctrl), .rx_data(rx_data),
    .rx_ready(rx_ready), .reg_req(reg_req), .reg_space(reg_space), .reg_size(reg_size),
    .reg_ack(reg_ack), .reg_err(reg_err), .tx_valid(tx_valid), .tx_ctrl(tx_ctrl),
    .tx_data(tx_data), .tx_dest(tx_dest), .tx_ready(tx_ready));
`default_nettype wire

//--- dv/cfgm_regs_model.sv
// behavioural register target answering the agent after a set latency
`timescale 1ns/1ns
`default_nettype none
module cfgm_regs_model
    import cfgm_pkg::*;
(
    // clock, reset and latency
    input wire logic clk,
    input wire logic resetn,
    input wire logic [3:0] lat,
    // register port
    input wire logic reg_req,
    input wire logic reg_we,
    input wire logic [1:0] reg_space,
    input wire logic [15:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    output logic reg_ack,
    output logic reg_err,
    output logic [31:0] reg_rdata
);
    logic [31:0] mem [0:63];
    logic [3:0] cnt;
    logic busy;
    // outside an answer the qualifiers toggle, so stale values are never trusted
    always @(posedge clk) begin
        reg_ack <= 1'b0;
        reg_err <= ~reg_err;
        reg_rdata <= ~reg_rdata;
        if (!resetn) begin
            busy <= 1'b0;
            reg_err <= 1'b0;
            reg_rdata <= 32'h0000_0000;
        end else if (reg_req) begin
            busy <= 1'b1;
            cnt <= lat;
        end else if (busy && cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
        end else if (busy) begin
            busy <= 1'b0;
            reg_ack <= 1'b1;
            reg_err <= reg_addr > 16'h000F;
            reg_rdata <= mem[{reg_space, reg_addr[3:0]}];
            if (reg_we && reg_addr <= 16'h000F) begin
                mem[{reg_space, reg_addr[3:0]}] <= reg_wdata;
            end
        end
    end
endmodule
`default_nettype wire

//--- dv/cfgm_agent_bench.sv
// self-checking bench for the configuration message agent
`timescale 1ns/1ns
`default_nettype none
module cfgm_agent_bench;
    import cfgm_pkg::*;
    localparam logic [15:0] TILE = 16'h0A31;
    localparam logic [15:0] NODE = 16'h05C7;
    logic clk, resetn, rx_valid, rx_ctrl, rx_ready, tx_valid, tx_ctrl, tx_ready;
    logic reg_req, reg_we, reg_ack, reg_err;
    logic [1:0] reg_space;
    logic [7:0] rx_data, reg_periph, reg_size, tx_data;
    logic [15:0] reg_addr;
    logic [31:0] rx_dest, reg_wdata, reg_rdata, cur_dest, d;
    logic [23:0] tx_dest, ret;
    logic [3:0] lat;
    logic [15:0] a;
    logic [32:0] expq [$];
    int num_errors, n_compared;

    cfgm_agent #(.MAX_PBYTES(4)) dut (
        .clk(clk), .resetn(resetn), .tile_id(TILE), .node_id(NODE), .rx_valid(rx_valid),
        .rx_ctrl(rx_ctrl), .rx_data(rx_data), .rx_dest(rx_dest), .rx_ready(rx_ready),
        .reg_req(reg_req), .reg_we(reg_we), .reg_space(reg_space), .reg_periph(reg_periph),
        .reg_addr(reg_addr), .reg_size(reg_size), .reg_wdata(reg_wdata), .reg_ack(reg_ack),
        .reg_err(reg_err), .reg_rdata(reg_rdata), .tx_valid(tx_valid), .tx_ctrl(tx_ctrl),
        .tx_data(tx_data), .tx_dest(tx_dest), .tx_ready(tx_ready));
    cfgm_regs_model u_regs (
        .clk(clk), .resetn(resetn), .lat(lat), .reg_req(reg_req), .reg_we(reg_we),
        .reg_space(reg_space), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_ack(reg_ack), .reg_err(reg_err), .reg_rdata(reg_rdata));

    // ------------------------------------------------------------
    // clock, sink stalls and reply monitor
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // the sink stalls about one cycle in four
    always @(negedge clk) begin
        tx_ready <= ($urandom % 4) != 0;
    end
    // every reply token taken is matched against the oldest note
    always @(posedge clk) begin
        if (resetn === 1'b1 && tx_valid === 1'b1 && tx_ready === 1'b1) begin
            if (expq.size() == 0) begin
                check({32'h0, 1'b1}, 33'h0);
            end else begin
                check({tx_ctrl, tx_data, tx_dest}, expq.pop_front());
            end
        end
    end

    // each access names the peripheral byte of the destination it was sent to
    always @(posedge clk) begin
        if (resetn === 1'b1 && reg_req === 1'b1) begin
            check({25'h0, reg_periph}, {25'h0, cur_dest[15:8]});
        end
    end

    task automatic check(input logic [32:0] seen, input logic [32:0] want);
        n_compared++;
        if (seen !== want) begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask

    task automatic results();
        if (num_errors == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // token drivers and expected replies
    // ------------------------------------------------------------
    task automatic tok(input logic c, input logic [7:0] v);
        int n;
        @(negedge clk);
        rx_valid = 1'b1;
        rx_ctrl = c;
        rx_data = v;
        rx_dest = cur_dest;
        n = 0;
        while (rx_ready !== 1'b1 && n < 500) begin
            @(negedge clk);
            n++;
        end
        check({32'h0, n < 500}, 33'h1);
        @(posedge clk);
    endtask

    // lead token, return id, nb body bytes msb first, end token
    task automatic send(input logic [7:0] lead, input int nb, input logic [63:0] body);
        int n;
        lat = 4'($urandom % 6);
        tok(1'b1, lead);
        for (int i = 2; i >= 0; i--) tok(1'b0, ret[8*i +: 8]);
        for (int i = nb - 1; i >= 0; i--) tok(1'b0, body[8*i +: 8]);
        tok(1'b1, TOK_END);
        @(negedge clk);
        rx_valid = 1'b0;
        rx_ctrl = 1'($urandom);
        rx_data = 8'($urandom);
        rx_dest = ~cur_dest;
        n = 0;
        while (expq.size() != 0 && n < 400) begin
            @(negedge clk);
            n++;
        end
        check({32'h0, n < 400}, 33'h1);
        ret = 24'($urandom);
    endtask

    task automatic expect_ok(input int nb, input logic [31:0] v);
        expq.push_back({1'b1, TOK_ACK, ret});
        for (int i = nb - 1; i >= 0; i--) expq.push_back({1'b0, v[8*i +: 8], ret});
        expq.push_back({1'b1, TOK_END, ret});
    endtask

    task automatic expect_fail();
        expq.push_back({1'b1, TOK_NACK, ret});
        expq.push_back({1'b1, TOK_END, ret});
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'h2437));
        {rx_valid, rx_ctrl, rx_data, rx_dest, lat, num_errors, n_compared} = '0;
        resetn = 1'b0;
        ret = 24'h5A_1C3E;
        repeat (3) @(posedge clk);
        @(negedge clk);
        resetn = 1'b1;
        // write, truncated write, then read back the old value
        for (int i = 0; i < 8; i++) begin
            cur_dest = (i % 2 != 0) ? {NODE, RES_NODE} : {TILE, RES_TILE};
            a = 16'($urandom % 16);
            d = $urandom;
            expect_ok(0, d);
            send(TOK_WRITE, 6, {16'h0, a, d});
            expect_fail();
            send(TOK_WRITE, 1, {56'h0, a[15:8]});
            expect_ok(4, d);
            send(TOK_READ, 2, {48'h0, a});
        end
        // peripheral write and read for every size
        for (int s = 1; s <= 4; s++) begin
            cur_dest = {NODE, 8'($urandom), RES_PERIPH};
            a = 16'($urandom % 16);
            d = $urandom & (32'hFFFF_FFFF >> (32 - 8 * s));
            expect_ok(0, d);
            send(TOK_PWRITE, 2 + s, ({48'h0, a[7:0], 8'(s)} << (8 * s)) | 64'(d));
            expect_ok(s, d);
            send(TOK_PREAD, 2, {48'h0, a[7:0], 8'(s)});
        end
        // refused requests: unknown register, overlong read, bad size, wrong or unknown token
        cur_dest = {TILE, RES_TILE};
        expect_fail();
        send(TOK_WRITE, 6, {16'h0, 16'h0123, 32'h1234_5678});
        expect_fail();
        send(8'h50, 2, 64'h0);
        expect_fail();
        send(TOK_READ, 3, 64'h0);
        cur_dest = {NODE, 8'h07, RES_PERIPH};
        expect_fail();
        send(TOK_PREAD, 2, {48'h0, 16'h0300});
        expect_fail();
        send(TOK_PREAD, 2, {48'h0, 16'h0305});
        expect_fail();
        send(TOK_WRITE, 6, 64'h0);
        // message to another node is swallowed with no reply
        cur_dest = {NODE ^ 16'h0001, RES_NODE};
        send(TOK_READ, 2, 64'h0);
        // give a stray reply time to show up before the verdict
        repeat (20) @(negedge clk);
        results();
    end

    // watchdog well beyond the expected run length
    initial begin
        #400_000;
        num_errors++;
        results();
    end
endmodule
`default_nettype wire
